// File: phase_shed_config_regs.sv
// Operation
// RQ1: Threshold config registers act only when both latches select registers.
// RQ2: A threshold register holding all ones disables that threshold.
// RQ3: Host programs thresholds with output-current readout codes at target.
// RQ4: Threshold status registers reload from straps on each enable rise.
// RQ5: A strap above the disable level reports a disabled threshold.
// RQ6: Hysteresis in threshold codes applies only when shedding phases.
// RQ7: Shedding waits the delay register, 10 us per code, default 200 us.
// RQ8: Any enable toggle returns all sources to strap resistor control.
// RQ9: A source change needs the same byte in both latches, any order.
// RQ10: Latch bit 5 picks register or strap for switching frequency.
// RQ11: Latch bit 4 picks register or strap for load line.
// RQ12: Latch bit 2 picks register or strap for overcurrent limit.
// RQ13: Latch bit 0 picks register or strap thresholds; others reserved.
// RQ14: Load-line and power-zone straps are sampled on each enable rise.
// RQ15: Differing latch bytes keep the previous effective selection.
// RQ16: Reserved latch bits read zero and ignore writes.
`include "phase_shed_defs.svh"

module phase_shed_config_regs
  import phase_shed_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire reg_req_t regReq,
  output logic [7:0] regRdData_q,
  input wire logic enable,
  input wire strap_t [3:0] thresholdStrap,
  input wire logic [1:0] loadLineStrap,
  input wire logic [2:0] powerZoneStrap,
  input wire logic [7:0] outputCurrentReadout,
  output logic [1:0] loadLineStrap_q,
  output logic [2:0] powerZoneStrap_q,
  output source_sel_t sourceSel_q,
  output logic [3:0][7:0] activeThreshold_q,
  output logic [3:0] thresholdOn_q,
  output logic [2:0] activePhases_q
);

  localparam logic [15:0] StepCycles = 16'(`STEP_CYCLES);

  function automatic logic [7:0] floorSub(
    input logic [7:0] a,
    input logic [7:0] b
  );
    floorSub = (a > b) ? a - b : 8'h00;
  endfunction

  // Phases on for a current code: one base phase plus each crossed level, at most four.
  function automatic logic [2:0] phaseCount(
    input logic [7:0] cur,
    input logic [3:0][7:0] th,
    input logic [3:0] on,
    input logic [7:0] hyst
  );
    logic [2:0] n;
    n = 3'h1;
    for (int i = 0; i < 4; i++) begin
      if (on[i] && cur >= floorSub(th[i], hyst) && n < 3'h4) begin
        n = n + 3'h1;
      end
    end
    phaseCount = n;
  endfunction

  logic [3:0][7:0] thCfg_q;
  logic [3:0][7:0] thStat_q;
  logic [7:0] hyst_q;
  logic [7:0] delay_q;
  logic [7:0] latchA_q;
  logic [7:0] latchB_q;
  logic enable_q;
  shed_state_t state_q;
  shed_state_t state_d;
  logic [15:0] stepCnt_q;
  logic [15:0] stepCnt_d;
  logic [7:0] delayCnt_q;
  logic [7:0] delayCnt_d;
  logic [2:0] phases_d;

  wire enableRise = enable && !enable_q;
  wire enableToggle = enable != enable_q;
  wire wrEn = regReq.write;
  wire [7:0] wrAddr = regReq.addr;
  wire [7:0] wrLatch = regReq.data & `LATCH_WR_MASK; // [RQ16]
  wire wrLatchA = wrEn && wrAddr == `LATCH_A_OFS;
  wire wrLatchB = wrEn && wrAddr == `LATCH_B_OFS;
  wire [7:0] nextA = wrLatchA ? wrLatch : latchA_q;
  wire [7:0] nextB = wrLatchB ? wrLatch : latchB_q;

  // Both halves must agree, so a single stray write cannot move a source.
  wire latchesMatch = nextA == nextB; // [RQ9] [RQ15]
  wire source_sel_t selMatched = '{
    switchFrequency: nextA[`SEL_FREQ_BIT], // [RQ10]
    loadLine: nextA[`SEL_LOADLINE_BIT], // [RQ11]
    overcurrentLimit: nextA[`SEL_OVERCUR_BIT], // [RQ12]
    shedThreshold: nextA[`SEL_THR_BIT] // [RQ13]
  };
  wire source_sel_t selNext = enableToggle ? source_sel_t'(4'h0) // [RQ8]
    : latchesMatch ? selMatched : sourceSel_q; // [RQ15]

  logic [3:0][7:0] strapCode;
  logic [3:0][7:0] thrSrc;
  logic [3:0] thrOn;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strapCode[i] = thresholdStrap[i].overLimit ? `THR_DISABLED // [RQ5]
        : thresholdStrap[i].code;
      thrSrc[i] = sourceSel_q.shedThreshold ? thCfg_q[i] // [RQ1]
        : thStat_q[i];
      thrOn[i] = thrSrc[i] != `THR_DISABLED; // [RQ2] [RQ5]
    end
  end

  // Current is compared with the same code scale the host programs.
  wire [2:0] upCount = phaseCount(outputCurrentReadout, // [RQ3]
    activeThreshold_q, thresholdOn_q, 8'h00);
  wire [2:0] downCount = phaseCount(outputCurrentReadout, // [RQ6]
    activeThreshold_q, thresholdOn_q, hyst_q);
  wire wantUp = upCount > activePhases_q;
  wire wantDown = downCount < activePhases_q;
  wire stepDone = stepCnt_q == StepCycles - 16'h0001;
  wire delayDone = delayCnt_q >= delay_q;

  // Adding phases is immediate; only shedding is held off by the delay.
  always_comb begin
    state_d = state_q;
    stepCnt_d = stepCnt_q;
    delayCnt_d = delayCnt_q;
    phases_d = activePhases_q;
    unique case (state_q)
      SHED_IDLE: begin
        stepCnt_d = 16'h0000;
        delayCnt_d = 8'h00;
        if (wantUp) begin
          phases_d = upCount;
        end else if (wantDown) begin
          state_d = SHED_WAIT;
        end
      end
      SHED_WAIT: begin
        if (wantUp || !wantDown) begin
          state_d = SHED_IDLE;
          if (wantUp) begin
            phases_d = upCount;
          end
        end else if (delayDone) begin // [RQ7]
          phases_d = downCount;
          state_d = SHED_IDLE;
        end else if (stepDone) begin
          stepCnt_d = 16'h0000;
          delayCnt_d = delayCnt_q + 8'h01;
        end else begin
          stepCnt_d = stepCnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = SHED_IDLE;
      end
    endcase
  end

  logic [7:0] rdMux;
  always_comb begin
    unique case (regReq.addr)
      `TH1_CFG_OFS: rdMux = thCfg_q[0];
      `TH1_STAT_OFS: rdMux = thStat_q[0];
      `TH2_CFG_OFS: rdMux = thCfg_q[1];
      `TH2_STAT_OFS: rdMux = thStat_q[1];
      `TH3_CFG_OFS: rdMux = thCfg_q[2];
      `TH3_STAT_OFS: rdMux = thStat_q[2];
      `TH4_CFG_OFS: rdMux = thCfg_q[3];
      `TH4_STAT_OFS: rdMux = thStat_q[3];
      `HYST_OFS: rdMux = hyst_q;
      `DELAY_OFS: rdMux = delay_q;
      `LATCH_A_OFS: rdMux = latchA_q; // [RQ16]
      `LATCH_B_OFS: rdMux = latchB_q; // [RQ16]
      default: rdMux = 8'h00;
    endcase
  end

  // One select line per writable register; status offsets decode to none.
  wire wrThCfg1 = wrEn && wrAddr == `TH1_CFG_OFS;
  wire wrThCfg2 = wrEn && wrAddr == `TH2_CFG_OFS;
  wire wrThCfg3 = wrEn && wrAddr == `TH3_CFG_OFS;
  wire wrThCfg4 = wrEn && wrAddr == `TH4_CFG_OFS;
  wire wrHyst = wrEn && wrAddr == `HYST_OFS;
  wire wrDelay = wrEn && wrAddr == `DELAY_OFS;
  wire [3:0] wrThCfg = {wrThCfg4, wrThCfg3, wrThCfg2, wrThCfg1};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thCfg_q <= {4{`TH_CFG_RST}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wrThCfg[i]) begin
          thCfg_q[i] <= regReq.data; // [RQ2]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hyst_q <= `HYST_RST;
    end else if (wrHyst) begin
      hyst_q <= regReq.data; // [RQ6]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      delay_q <= 8'(`DELAY_RST); // [RQ7]
    end else if (wrDelay) begin
      delay_q <= regReq.data; // [RQ7]
    end
  end

  // Straps are only meaningful as the regulator starts, so catch them there.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thStat_q <= {4{`TH_STAT_RST}};
      loadLineStrap_q <= 2'h0;
      powerZoneStrap_q <= 3'h0;
    end else if (enableRise) begin
      thStat_q <= strapCode; // [RQ4]
      loadLineStrap_q <= loadLineStrap; // [RQ14]
      powerZoneStrap_q <= powerZoneStrap; // [RQ14]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latchA_q <= `LATCH_RST;
    end else if (enableToggle) begin
      latchA_q <= `LATCH_RST; // [RQ8]
    end else begin
      latchA_q <= nextA; // [RQ9]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latchB_q <= `LATCH_RST;
    end else if (enableToggle) begin
      latchB_q <= `LATCH_RST; // [RQ8]
    end else begin
      latchB_q <= nextB; // [RQ9]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sourceSel_q <= source_sel_t'(4'h0);
    end else begin
      sourceSel_q <= selNext; // [RQ15]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      activeThreshold_q <= {4{`THR_DISABLED}};
    end else begin
      activeThreshold_q <= thrSrc; // [RQ1]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thresholdOn_q <= 4'h0;
    end else begin
      thresholdOn_q <= thrOn; // [RQ2]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SHED_IDLE;
      stepCnt_q <= 16'h0000;
      delayCnt_q <= 8'h00;
      activePhases_q <= 3'h1;
    end else begin
      state_q <= state_d;
      stepCnt_q <= stepCnt_d;
      delayCnt_q <= delayCnt_d;
      activePhases_q <= phases_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdData_q <= 8'h00;
    end else if (regReq.read) begin
      regRdData_q <= rdMux;
    end
  end

endmodule

// File: phase_shed_defs.svh
`ifndef PHASE_SHED_DEFS_SVH
`define PHASE_SHED_DEFS_SVH

`define TH1_CFG_OFS 8'h3A
`define TH1_STAT_OFS 8'h3B
`define TH2_CFG_OFS 8'h3C
`define TH2_STAT_OFS 8'h3D
`define TH3_CFG_OFS 8'h3E
`define TH3_STAT_OFS 8'h3F
`define TH4_CFG_OFS 8'h40
`define TH4_STAT_OFS 8'h41
`define HYST_OFS 8'h44
`define DELAY_OFS 8'h45
`define LATCH_A_OFS 8'h46
`define LATCH_B_OFS 8'h47

`define SEL_FREQ_BIT 5
`define SEL_LOADLINE_BIT 4
`define SEL_OVERCUR_BIT 2
`define SEL_THR_BIT 0
`define LATCH_WR_MASK 8'h35

`define THR_DISABLED 8'hFF
`define TH_CFG_RST 8'hFF
`define TH_STAT_RST 8'hFF
`define HYST_RST 8'h00
`define LATCH_RST 8'h00

`define CLK_PERIOD_NS 25
`define DELAY_STEP_US 10
`define DELAY_DEFAULT_US 200
`define DELAY_RST (`DELAY_DEFAULT_US / `DELAY_STEP_US)
`define STEP_CYCLES (`DELAY_STEP_US * 1000 / `CLK_PERIOD_NS)

`endif

// File: phase_shed_pkg.sv
package phase_shed_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic overLimit;
    logic [7:0] code;
  } strap_t;

  typedef struct packed {
    logic switchFrequency;
    logic loadLine;
    logic overcurrentLimit;
    logic shedThreshold;
  } source_sel_t;

  typedef enum logic [1:0] {
    SHED_IDLE = 2'b00,
    SHED_WAIT = 2'b01
  } shed_state_t;

endpackage

// File: phase_shed_monitor.sv
module phase_shed_monitor
  import phase_shed_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire reg_req_t regReq,
  input wire logic [7:0] regRdData_q,
  input wire logic enable,
  input wire strap_t [3:0] thresholdStrap,
  input wire logic [1:0] loadLineStrap,
  input wire logic [1:0] loadLineStrap_q,
  input wire source_sel_t sourceSel_q,
  input wire logic [3:0][7:0] activeThreshold_q,
  input wire logic [3:0] thresholdOn_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic [7:0] d = regReq.data;
  wire logic wA = regReq.write && regReq.addr == 8'h46;
  wire logic wB = regReq.write && regReq.addr == 8'h47;
  a_toggle_clears_sel: assert property (
    $changed(enable) |=> !sourceSel_q)
    else $error("selection kept over enable change");
  a_strap_capture: assert property ($rose(enable) |=>
    loadLineStrap_q == $past(loadLineStrap)) else $error("strap not captured");
  a_sel_holds_idle: assert property (
    (!regReq.write && $stable(enable)) [*2] |=> $stable(sourceSel_q))
    else $error("selection moved without cause");
  a_reserved_zero: assert property (
    regReq.read && regReq.addr[7:1] == 7'h23 |=> !(regRdData_q & 8'hCA))
    else $error("reserved latch bit read high");
  a_strap_threshold: assert property ($rose(enable) |=> ##1
    activeThreshold_q[0] == ($past(thresholdStrap[0].overLimit, 2) ?
    8'hFF : $past(thresholdStrap[0].code, 2))) else $error("strap threshold");
  a_strap_disable: assert property ($rose(enable) |=> ##1
    thresholdOn_q[3] == (!$past(thresholdStrap[3].overLimit, 2) &&
    $past(thresholdStrap[3].code, 2) != 8'hFF)) else $error("strap disable");
  a_delay_readback: assert property (
    regReq.write && !regReq.read && regReq.addr == 8'h45 ##2 regReq.read &&
    !regReq.write && regReq.addr == 8'h45 |=> regRdData_q == $past(d, 3))
    else $error("delay readback wrong");
  a_latch_pair: assert property (
    wA && $stable(enable) ##2 wB && d == $past(d, 2) &&
    $stable(enable) && $past(enable, 2) == enable |=> sourceSel_q ==
    {$past(d[5]), $past(d[4]), $past(d[2]), $past(d[0])})
    else $error("latch pair not applied");
  c_all_regs: cover property (sourceSel_q == 4'hF);
  c_enable_rise: cover property ($rose(enable));
  c_thr_cfg: cover property (sourceSel_q == 4'h1 && thresholdOn_q == 4'h7);
endmodule

bind phase_shed_config_regs phase_shed_monitor i_mon (.clk, .reset_n,
  .regReq, .regRdData_q, .enable, .thresholdStrap, .loadLineStrap,
  .loadLineStrap_q, .sourceSel_q, .activeThreshold_q, .thresholdOn_q);

// File: reg_host.sv
module reg_host
  import phase_shed_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] regRdData_q,
  output reg_req_t regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial regReq = '0;
  // An idle cycle follows each request, so a held strobe never repeats.
  task automatic xfer(input logic [7:0] a, dat, input logic w,
                      output logic [7:0] q);
    @(posedge clk);
    #2 regReq = '{a, dat, w, !w};
    @(posedge clk);
    #2 regReq = '0;
    q = regRdData_q;
  endtask
endmodule

// File: phase_shed_config_regs_test.sv
module phase_shed_config_regs_test
  import phase_shed_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, reset_n = 1'h0, enable = 1'h0;
  reg_req_t regReq;
  strap_t [3:0] thresholdStrap = '0;
  logic [1:0] loadLineStrap = 2'h0, loadLineStrap_q;
  logic [2:0] powerZoneStrap = 3'h5, powerZoneStrap_q, activePhases_q;
  logic [7:0] outputCurrentReadout = 8'h00, regRdData_q, q;
  logic [7:0] thr[4] = '{8'h28, 8'h50, 8'h78, 8'hFF};
  source_sel_t sourceSel_q;
  logic [3:0][7:0] activeThreshold_q;
  logic [3:0] thresholdOn_q;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h0A63794B;
  phase_shed_config_regs i_dut (.clk, .reset_n, .regReq, .regRdData_q,
    .enable, .thresholdStrap, .loadLineStrap, .powerZoneStrap,
    .outputCurrentReadout, .loadLineStrap_q, .powerZoneStrap_q,
    .sourceSel_q, .activeThreshold_q, .thresholdOn_q, .activePhases_q);
  reg_host i_host (.clk, .regRdData_q, .regReq);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Thresholds one to three are live, the fourth holds the off code.
  function automatic logic [7:0] expPh(input logic [7:0] c);
    return 8'h1 + 8'(c >= thr[0]) + 8'(c >= thr[1]) + 8'(c >= thr[2]);
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, dat);
    i_host.xfer(a, dat, 1'b1, q);
  endtask
  task automatic rdc(input logic [7:0] a, e, input string n);
    logic [7:0] v;
    i_host.xfer(a, 8'h00, 1'b0, v);
    chk(n, v, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    wait_cyc(6);
    reset_n = 1'h1;
    rdc(8'h3A, 8'hFF, "cfg1");
    rdc(8'h45, 8'h14, "delay");
    rdc(8'h44, 8'h00, "hyst");
    rdc(8'h46, 8'h00, "latchA");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      thresholdStrap[i] = '{i == 2, {1'b0, seed[6:0]}};
    end
    loadLineStrap = seed[9:8];
    enable = 1'h1;
    wait_cyc(3);
    chk("llq", 8'(loadLineStrap_q), 8'(loadLineStrap));
    chk("pz", 8'(powerZoneStrap_q), 8'(powerZoneStrap));
    chk("on", 8'(thresholdOn_q), 8'h0B);
    chk("act", activeThreshold_q[1], thresholdStrap[1].code);
    for (int i = 0; i < 4; i++) begin
      wr(8'h3B + 8'(2 * i), 8'h00);
      q = i == 2 ? 8'hFF : thresholdStrap[i].code;
      rdc(8'h3B + 8'(2 * i), q, "st");
    end
    foreach (thr[i]) wr(8'h3A + 8'(2 * i), thr[i]);
    wr(8'h46, 8'hFF);
    chk("half", 8'(sourceSel_q), 8'h00);
    wr(8'h47, 8'hFF);
    chk("pair", 8'(sourceSel_q), 8'h0F);
    rdc(8'h46, 8'h35, "resv");
    chk("cfg", activeThreshold_q[1], thr[1]);
    chk("off", 8'(thresholdOn_q), 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(8'h47, 8'h20 >> (i == 3 ? 5 : i + (i > 1)));
      wr(8'h46, 8'h20 >> (i == 3 ? 5 : i + (i > 1)));
      chk("src", 8'(sourceSel_q), 8'h08 >> i);
    end
    wr(8'h45, 8'h01);
    rdc(8'h45, 8'h01, "delay");
    wr(8'h44, 8'h04);
    seed = lfsr(seed);
    outputCurrentReadout = 8'h78 + {1'b0, seed[6:0]};
    wait_cyc(3);
    chk("up", 8'(activePhases_q), expPh(outputCurrentReadout));
    outputCurrentReadout = 8'h76;
    wait_cyc(500);
    chk("hyst", 8'(activePhases_q), 8'h04);
    outputCurrentReadout = 8'h60;
    wait_cyc(300);
    chk("early", 8'(activePhases_q), 8'h04);
    wait_cyc(160);
    chk("shed", 8'(activePhases_q), expPh(8'h60));
    enable = 1'h0;
    wait_cyc(2);
    chk("clr", 8'(sourceSel_q), 8'h00);
    rdc(8'h47, 8'h00, "latchB");
    finish_test();
  end
endmodule
